// ---- rtl/sscfg_pkg.sv ----
// Package of the scan and drive configuration bank: offsets, fields, resets.
// Assumes an APB slave with 32-bit data; registers sit in the low 16 bits.
package sscfg_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_MAIN_CONFIG   = 8'h1a;
  localparam logic [7:0]  IDX_SCAN_CONFIG   = 8'h1b;
  localparam logic [7:0]  IDX_RESET_GAIN    = 8'h1c;
  localparam logic [7:0]  IDX_DRIVE_CHAN0   = 8'h1e;
  localparam logic [7:0]  IDX_DRIVE_CHAN1   = 8'h1f;
  localparam logic [7:0]  IDX_DRIVE_CHAN2   = 8'h20;
  localparam logic [7:0]  IDX_DRIVE_CHAN3   = 8'h21;
  localparam logic [7:0]  IDX_CAL_INPUT     = 8'h40;

  localparam logic [15:0] RST_MAIN_CONFIG   = 16'h2801;
  localparam logic [15:0] RST_SCAN_CONFIG   = 16'h020f;
  localparam logic [15:0] RST_RESET_GAIN    = 16'h0000;
  localparam logic [15:0] RST_DRIVE         = 16'h0000;
  localparam logic [4:0]  RST_DRIVE_FIELD   = 5'h00;
  localparam logic [1:0]  RST_CHAN          = 2'h0;

  localparam int SCAN_ON_BIT       = 15;
  localparam int SCAN_ORDER_LSB    = 13;
  localparam int FILTER_LSB        = 0;
  localparam int SOFT_RESET_BIT    = 15;
  localparam int GAIN_LSB          = 9;
  localparam int PROG_DRIVE_LSB    = 11;
  localparam int CAL_DRIVE_LSB     = 6;
  localparam int SINGLE_CHANNEL_SELECT_LSB   = 14;
  localparam int OVERRIDE_BIT      = 12;
  localparam int AMP_OFF_BIT       = 10;
  localparam int BOOST_BIT         = 6;

  localparam logic [15:0] SCAN_CONFIG_WMASK = 16'hfff8 | 16'h0007;
  localparam logic [15:0] RESET_GAIN_WMASK  = 16'h7fff;
  localparam logic [15:0] DRIVE_WMASK       = 16'hf800;

  // Deglitch bandwidth codes
  localparam logic [2:0]  FILTER_1MHZ   = 3'h1;
  localparam logic [2:0]  FILTER_3M3HZ  = 3'h4;
  localparam logic [2:0]  FILTER_10MHZ  = 3'h5;
  localparam logic [2:0]  FILTER_33MHZ  = 3'h7;

  typedef enum logic [1:0] {
    SSCFG_FILT_1M,
    SSCFG_FILT_3M3,
    SSCFG_FILT_10M,
    SSCFG_FILT_33M
  } sscfg_filter_t;

  // Settings handed to the converter core
  typedef struct packed {
    logic [1:0]    chan;
    logic [4:0]    drive;
    logic          override_on;
    logic          boost;
    logic [2:0]    gain_shift;
    sscfg_filter_t filter;
  } sscfg_conv_t;

  // One amplitude correction result from the core
  typedef struct packed {
    logic       valid;
    logic [1:0] chan;
    logic [4:0] drive;
  } sscfg_cal_t;

endpackage : sscfg_pkg

// ---- rtl/sscfg_sequencer.sv ----
// Channel sequencer: picks the channel for each conversion.
// Assumes conv_done pulses once per finished conversion on the same clock.
module sscfg_sequencer
  import sscfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       scan_on,
  input  wire logic [1:0] scan_order,
  input  wire logic [1:0] single_chan,
  input  wire logic       four_chan,
  input  wire logic       conv_done,
  output logic      [1:0] chan
);

  logic [1:0] last_chan;
  logic [1:0] next_chan;

  always_comb begin
    last_chan = 2'h1;
    case (scan_order)
      2'h1:    last_chan = four_chan ? 2'h2 : 2'h1;
      2'h2:    last_chan = four_chan ? 2'h3 : 2'h1;
      default: last_chan = 2'h1;
    endcase
  end

  always_comb begin
    if (!scan_on) begin
      next_chan = single_chan;
    end else if (conv_done) begin
      next_chan = (chan >= last_chan) ? 2'h0 : 2'(chan + 2'h1);
    end else if (chan > last_chan) begin
      next_chan = 2'h0;
    end else begin
      next_chan = chan;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      chan <= RST_CHAN;
    end else begin
      chan <= next_chan;
    end
  end

endmodule : sscfg_sequencer

// ---- rtl/sscfg_top.sv ----
// Scan and drive configuration bank with APB slave and channel sequencer.
// Assumes APB3 master on CLK; converter core reports conversions and calibration.
//
// Function
// - Scan off: convert continuously on the single selected channel only.
// - Scan on: convert following the scan order field.
// - Scan converts each listed channel once in order, then restarts.
// - Order 00/11: ch0-1; 01: ch0-2 and 10: ch0-3, both four-channel part only.
// - Filter code selects deglitch bandwidth 1/3.3/10/33 MHz; resets to 111.
// - Writing one to soft reset bit 15 resets the whole device.
// - Soft reset bit always reads back zero.
// - Gain field selects result shift 0, 2, 3 or 4 bits.
// - Per-channel programmed drive sets current during settling and conversion.
// - Read-only per-channel field holds calibrated initial drive current.
// - Calibrated field updated after each correction while correction enabled.
// - Active channel field picks the single converted channel 0 to 3.
// - Correction-off bit stops correction and freezes calibrated fields.
module sscfg_top
  import sscfg_pkg::*;
#(
  parameter bit FOUR_CHAN = 1'b1
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        CONV_DONE,
  input  wire sscfg_cal_t  CAL_RESULT,
  output sscfg_conv_t      CONV_CFG,
  output logic             SCAN_ON,
  output logic             AMP_CORR_OFF,
  output logic             DEVICE_RESET
);

  logic [15:0] main_config;
  logic [15:0] channel_scan_config;
  logic [15:0] soft_reset_and_gain;
  logic [4:0]  prog_drive [4];
  logic [4:0]  cal_drive  [4];
  logic        soft_reset_bit;
  logic        bank_reset;
  logic        access;
  logic        wr;
  logic [7:0]  index;
  logic        mapped;
  logic [15:0] read_word;
  logic [1:0]  chan;
  logic        chan_valid;

  function automatic logic [2:0] gain_to_shift(input logic [1:0] gain);
    case (gain)
      2'h0:    gain_to_shift = 3'h0;
      2'h1:    gain_to_shift = 3'h2;
      2'h2:    gain_to_shift = 3'h3;
      default: gain_to_shift = 3'h4;
    endcase
  endfunction : gain_to_shift

  function automatic sscfg_filter_t filter_decode(input logic [2:0] code);
    case (code)
      FILTER_1MHZ:  filter_decode = SSCFG_FILT_1M;
      FILTER_3M3HZ: filter_decode = SSCFG_FILT_3M3;
      FILTER_10MHZ: filter_decode = SSCFG_FILT_10M;
      default:      filter_decode = SSCFG_FILT_33M;
    endcase
  endfunction : filter_decode

  function automatic logic is_drive(input logic [7:0] idx);
    is_drive = (idx == IDX_DRIVE_CHAN0) || (idx == IDX_DRIVE_CHAN1) ||
               (FOUR_CHAN && ((idx == IDX_DRIVE_CHAN2) || (idx == IDX_DRIVE_CHAN3)));
  endfunction : is_drive

  function automatic logic [1:0] drive_chan(input logic [7:0] idx);
    drive_chan = 2'(idx - IDX_DRIVE_CHAN0) ^ 2'h0;
  endfunction : drive_chan

  assign index  = PADDR[9:2];
  assign access = PSEL && PENABLE;
  assign mapped = (PADDR[31:10] == 22'h0) && (PADDR[1:0] == 2'h0) &&
                  ((index == IDX_MAIN_CONFIG) || (index == IDX_SCAN_CONFIG) ||
                   (index == IDX_RESET_GAIN) || is_drive(index));
  assign wr     = access && PWRITE && mapped;

  // Soft reset is applied one cycle after the write, then clears itself
  assign soft_reset_bit = wr && (index == IDX_RESET_GAIN) && PWDATA[SOFT_RESET_BIT];
  assign bank_reset     = SRST || DEVICE_RESET;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      DEVICE_RESET <= 1'b0;
    end else begin
      DEVICE_RESET <= soft_reset_bit;
    end
  end

  always_ff @(posedge CLK) begin
    if (bank_reset) begin
      main_config <= RST_MAIN_CONFIG;
    end else if (wr && (index == IDX_MAIN_CONFIG)) begin
      main_config <= PWDATA[15:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (bank_reset) begin
      channel_scan_config <= RST_SCAN_CONFIG;
    end else if (wr && (index == IDX_SCAN_CONFIG)) begin
      channel_scan_config <= PWDATA[15:0] & SCAN_CONFIG_WMASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (bank_reset) begin
      soft_reset_and_gain <= RST_RESET_GAIN;
    end else if (wr && (index == IDX_RESET_GAIN)) begin
      soft_reset_and_gain <= PWDATA[15:0] & RESET_GAIN_WMASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (bank_reset) begin
      for (int i = 0; i < 4; i++) begin
        prog_drive[i] <= RST_DRIVE_FIELD;
      end
    end else if (wr && is_drive(index)) begin
      prog_drive[drive_chan(index)] <= PWDATA[PROG_DRIVE_LSB +: 5];
    end
  end

  always_ff @(posedge CLK) begin
    if (bank_reset) begin
      for (int i = 0; i < 4; i++) begin
        cal_drive[i] <= RST_DRIVE_FIELD;
      end
    end else if (CAL_RESULT.valid && !main_config[AMP_OFF_BIT]) begin
      cal_drive[CAL_RESULT.chan] <= CAL_RESULT.drive;
    end
  end

  always_comb begin
    read_word = 16'h0000;
    if (index == IDX_MAIN_CONFIG) begin
      read_word = main_config;
    end else if (index == IDX_SCAN_CONFIG) begin
      read_word = channel_scan_config;
    end else if (index == IDX_RESET_GAIN) begin
      read_word = soft_reset_and_gain;
    end else if (is_drive(index)) begin
      read_word = RST_DRIVE;
      read_word[PROG_DRIVE_LSB +: 5] = prog_drive[drive_chan(index)];
      read_word[CAL_DRIVE_LSB +: 5]  = cal_drive[drive_chan(index)];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= mapped ? {16'h0000, read_word} : 32'h0000_0000;
    end
  end

  // Zero-wait slave: setup cycle latches read data, access completes at once
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !mapped;

  sscfg_sequencer #() u_seq (
    .clk         (CLK),
    .srst        (bank_reset),
    .scan_on     (channel_scan_config[SCAN_ON_BIT]),
    .scan_order  (channel_scan_config[SCAN_ORDER_LSB +: 2]),
    .single_chan (main_config[SINGLE_CHANNEL_SELECT_LSB +: 2]),
    .four_chan   (FOUR_CHAN),
    .conv_done   (CONV_DONE),
    .chan        (chan)
  );

  assign chan_valid = FOUR_CHAN || !chan[1];

  always_ff @(posedge CLK) begin
    if (bank_reset) begin
      CONV_CFG     <= '0;
      SCAN_ON      <= 1'b0;
      AMP_CORR_OFF <= 1'b0;
    end else begin
      CONV_CFG.chan        <= chan_valid ? chan : 2'h0;
      CONV_CFG.drive       <= prog_drive[chan];
      CONV_CFG.override_on <= main_config[OVERRIDE_BIT];
      CONV_CFG.boost       <= main_config[BOOST_BIT];
      CONV_CFG.gain_shift  <= gain_to_shift(soft_reset_and_gain[GAIN_LSB +: 2]);
      CONV_CFG.filter      <= filter_decode(channel_scan_config[FILTER_LSB +: 3]);
      SCAN_ON              <= channel_scan_config[SCAN_ON_BIT];
      AMP_CORR_OFF         <= main_config[AMP_OFF_BIT];
    end
  end

endmodule : sscfg_top

// ---- sim/sscfg_properties.sv ----
// Checker of the scan and drive configuration bank.
// Assumes it is bound to sscfg_top and sees only that module's ports.
module sscfg_checker
  import sscfg_pkg::*;
#(
  parameter bit FOUR_CHAN = 1'b1
) (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        CONV_DONE,
  input wire sscfg_cal_t  CAL_RESULT,
  input wire sscfg_conv_t CONV_CFG,
  input wire logic        SCAN_ON,
  input wire logic        AMP_CORR_OFF,
  input wire logic        DEVICE_RESET
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  logic       acc;
  logic       wm;
  logic       ws;
  logic       wg;
  logic [1:0] act;
  logic [1:0] ord;
  assign acc = PSEL && PENABLE;
  assign wm  = acc && PWRITE && PADDR == 32'h68;
  assign ws  = acc && PWRITE && PADDR == 32'h6c;
  assign wg  = acc && PWRITE && PADDR == 32'h70;

  // Shadow of the single channel and scan order fields
  always_ff @(posedge CLK) begin
    if (SRST || DEVICE_RESET) begin
      act <= 2'h0;
      ord <= 2'h0;
    end else begin
      if (wm) act <= PWDATA[15:14];
      if (ws) ord <= PWDATA[14:13];
    end
  end

  function automatic logic [1:0] nxt(input logic [1:0] c);
    logic [1:0] last;
    last = !FOUR_CHAN ? 2'h1 : (ord == 2'h1 ? 2'h2 : (ord == 2'h2 ? 2'h3 : 2'h1));
    return (c == last) ? 2'h0 : c + 2'h1;
  endfunction : nxt

  function automatic sscfg_filter_t fmap(input logic [2:0] f);
    return f == 3'h1 ? SSCFG_FILT_1M : f == 3'h4 ? SSCFG_FILT_3M3 :
           f == 3'h5 ? SSCFG_FILT_10M : SSCFG_FILT_33M;
  endfunction : fmap

  AST_SCAN_MIRROR: assert property (ws |-> ##2 SCAN_ON == $past(PWDATA[15], 2))
    else $error("scan enable output does not follow its register bit");
  AST_RESET_PULSE: assert property (wg && PWDATA[15] |=> DEVICE_RESET ##1 !DEVICE_RESET)
    else $error("device reset pulse missing or too long");
  AST_RESET_RESTORES: assert property (DEVICE_RESET |-> ##[1:4]
    (!SCAN_ON && !AMP_CORR_OFF && CONV_CFG.chan == 2'h0))
    else $error("soft reset did not restore configuration");
  AST_SINGLE_CHAN: assert property ((!SCAN_ON && $stable(act))[*4] |-> CONV_CFG.chan == act)
    else $error("single channel mode converts wrong channel");
  AST_SCAN_ADVANCE: assert property ((SCAN_ON && !ws)[*4] ##0 CONV_DONE |=> ##1
    CONV_CFG.chan == nxt($past(CONV_CFG.chan)))
    else $error("scan sequence stepped to wrong channel");
  AST_AMP_MIRROR: assert property (wm |-> ##2 AMP_CORR_OFF == $past(PWDATA[10], 2))
    else $error("correction disable output does not follow register");
  AST_GAIN: assert property (wg && !PWDATA[15] |-> ##2
    CONV_CFG.gain_shift == ($past(PWDATA[10:9], 2) == 2'h0 ? 3'h0 : 3'($past(PWDATA[10:9], 2)) + 3'h1))
    else $error("gain shift does not match gain field");
  AST_FILTER: assert property (ws |-> ##2 CONV_CFG.filter == fmap($past(PWDATA[2:0], 2)))
    else $error("deglitch bandwidth does not match filter field");
  AST_RD_ZERO: assert property (acc && !PWRITE && PADDR == 32'h70 |-> PRDATA[31:15] == 17'h0)
    else $error("soft reset bit read back as one");

  cover property (SCAN_ON && CONV_DONE);
  cover property (DEVICE_RESET);
  cover property (CAL_RESULT.valid && AMP_CORR_OFF);
endmodule : sscfg_checker

bind sscfg_top sscfg_checker #(.FOUR_CHAN(FOUR_CHAN)) u_chk (
  .CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
  .CONV_DONE, .CAL_RESULT, .CONV_CFG, .SCAN_ON, .AMP_CORR_OFF, .DEVICE_RESET
);

// ---- sim/tb_sscfg_top.sv ----
// Testbench of the scan and drive configuration bank over APB.
// Assumes a zero-wait APB slave and the converter side driven by the bench.
module tb_sscfg_top
  import sscfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic          CLK;
  logic          SRST;
  logic          PSEL;
  logic          PENABLE;
  logic          PWRITE;
  logic [31:0]   PADDR;
  logic [31:0]   PWDATA;
  logic [31:0]   PRDATA;
  logic          PREADY;
  logic          PSLVERR;
  logic          CONV_DONE;
  sscfg_cal_t    CAL_RESULT;
  sscfg_conv_t   CONV_CFG;
  logic          SCAN_ON;
  logic          AMP_CORR_OFF;
  logic          DEVICE_RESET;
  int            failures;
  int            num_checks;
  logic [31:0]   rd;
  logic          err;
  logic [2:0]    fc [4] = '{3'h1, 3'h4, 3'h5, 3'h7};
  sscfg_filter_t fe [4] = '{SSCFG_FILT_1M, SSCFG_FILT_3M3, SSCFG_FILT_10M, SSCFG_FILT_33M};

  sscfg_top dut (
    .CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .CONV_DONE, .CAL_RESULT, .CONV_CFG, .SCAN_ON, .AMP_CORR_OFF, .DEVICE_RESET
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rchk

  // One-cycle pulse on the converter side, then let the outputs settle
  task automatic tick(input logic done, input sscfg_cal_t cal);
    @(posedge CLK);
    CONV_DONE  <= done;
    CAL_RESULT <= cal;
    @(posedge CLK);
    CONV_DONE  <= 1'b0;
    CAL_RESULT <= '0;
    repeat (3) @(posedge CLK);
    #1;
  endtask : tick

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  initial begin
    logic [1:0] c;
    failures = 0;
    num_checks = 0;
    SRST = 1'b1;
    {PSEL, PENABLE, PWRITE, CONV_DONE} = 4'h0;
    PADDR = 32'h0;
    PWDATA = 32'h0;
    CAL_RESULT = '0;
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
    rchk(32'h6c, 32'h020f);
    rchk(32'h70, 32'h0);
    rchk(32'h78, 32'h0);
    check(32'(err), 32'h0);
    check(32'(PREADY), 32'h1);
    rchk(32'h74, 32'h0);
    check(32'(err), 32'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 32'h70, 32'(i) << 9);
      apb(1'b1, 32'h6c, 32'h0208 | 32'(fc[i]));
      tick(1'b0, '0);
      check(32'(CONV_CFG.gain_shift), i == 0 ? 32'h0 : 32'(i + 1));
      check(32'(CONV_CFG.filter), 32'(fe[i]));
    end
    apb(1'b1, 32'h78, 32'hffff);
    rchk(32'h78, 32'hf800);
    check(32'(CONV_CFG.drive), 32'h1f);
    tick(1'b0, '{1'b1, 2'h1, 5'h15});
    rchk(32'h7c, 32'h0540);
    apb(1'b1, 32'h68, 32'h2c01);
    tick(1'b0, '{1'b1, 2'h1, 5'h0a});
    check(32'(AMP_CORR_OFF), 32'h1);
    rchk(32'h7c, 32'h0540);
    apb(1'b1, 32'h68, 32'hb841);
    tick(1'b1, '0);
    check(32'(CONV_CFG.chan), 32'h2);
    check(32'(CONV_CFG.override_on), 32'h1);
    check(32'(CONV_CFG.boost), 32'h1);
    apb(1'b1, 32'h68, 32'h2801);
    for (int o = 0; o < 4; o++) begin
      apb(1'b1, 32'h6c, 32'h020f);
      apb(1'b1, 32'h6c, 32'h820f | (32'(o) << 13));
      c = 2'h0;
      for (int k = 0; k < 5; k++) begin
        tick(1'b1, '0);
        c = (c == (o == 1 ? 2'h2 : o == 2 ? 2'h3 : 2'h1)) ? 2'h0 : c + 2'h1;
        check(32'(CONV_CFG.chan), 32'(c));
      end
      check(32'(SCAN_ON), 32'h1);
    end
    apb(1'b1, 32'h70, 32'h8000);
    #1;
    check(32'(DEVICE_RESET), 32'h1);
    rchk(32'h70, 32'h0);
    rchk(32'h6c, 32'h020f);
    rchk(32'h7c, 32'h0);
    tally_and_finish();
  end
endmodule : tb_sscfg_top
